//--- sce_top.sv
// System configuration, error query and lockout command block
`timescale 1ns/1ps

// ****************************************************************
// Top of the system command block
// ****************************************************************
module sce_top
  import sce_pkg::*;
#(
  parameter int DEPTH = ERRQ_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Decoded command from the link parser
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic cmd_is_set_i,
  input wire logic [ARG_W-1:0] cmd_arg_i,
  // Error logging from the rest of the instrument
  input wire logic err_log_i,
  input wire logic [CODE_W-1:0] err_code_i,
  // Enable requests from panel or commands
  input wire logic laser_en_req_i,
  input wire logic cooler_en_req_i,
  // Reply to the parser
  output logic rsp_valid_o,
  output logic [CODE_W-1:0] rsp_value_o,
  output logic rsp_text_o,
  // Mode and option outputs
  output logic remote_o,
  output logic ramp_o,
  output logic vf_sense_sel_o,
  output logic laser_en_o,
  output logic cooler_en_o,
  output logic buttons_en_o,
  output logic knob_en_o,
  output logic [OPT_W-1:0] options_o,
  output logic [LOCK_W-1:0] lockout_o
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic remote;
    logic [OPT_W-1:0] opt;
    logic [LOCK_W-1:0] lock;
    logic rsp_valid;
    logic [CODE_W-1:0] rsp_value;
    logic rsp_text;
    logic ramp;
    logic vf_sel;
    logic laser_en;
    logic cooler_en;
    logic buttons_en;
    logic knob_en;
  } sce_state_s;

  sce_state_s st;
  sce_state_s next_st;

  sce_cmd_e cmd; // Command seen as enum
  logic err_pop; // Take one entry from the queue
  logic [CODE_W-1:0] err_head; // Oldest pending code or zero
  logic err_empty; // Nothing pending

  assign cmd = sce_cmd_e'(cmd_code_i);

  // ****************************************************************
  // Error queue
  // ****************************************************************
  // Popped only by a valid error query of either kind
  assign err_pop = cmd_valid_i && ((cmd == CMD_ERR_QUERY) || (cmd == CMD_ERR_TEXT_QUERY)); // R2

  sce_errq #(
    .DEPTH(DEPTH),
    .W(CODE_W)
  ) u_errq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(err_log_i),
    .push_code_i(err_code_i),
    .pop_i(err_pop),
    .head_o(err_head),
    .empty_o(err_empty)
  );

  // ****************************************************************
  // Command handling
  // ****************************************************************
  // All replies come one cycle after the command
  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_text = 1'b0;
    if (cmd_valid_i) begin
      // Remote entry policy follows option bit 0
      if (!st.opt[OPT_REMOTE_SET_ONLY]) begin
        next_st.remote = 1'b1; // R5
      end else if (cmd_is_set_i) begin
        next_st.remote = 1'b1; // R6
      end
      case (cmd)
        CMD_ERR_QUERY: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_value = err_head; // R1
        end
        CMD_ERR_TEXT_QUERY: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_value = err_head; // R3
          // Text follows only a real code; zero goes bare
          next_st.rsp_text = !err_empty; // R3
        end
        CMD_OPT_WRITE: begin
          // Out-of-range values are ignored, register unchanged
          if (cmd_arg_i <= OPT_MAX) begin
            next_st.opt = cmd_arg_i[OPT_W-1:0]; // R4 R15
          end
        end
        CMD_OPT_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_value = CODE_W'(st.opt); // R12
        end
        CMD_LOCAL: begin
          // Wins over the entry above in the same cycle
          next_st.remote = 1'b0; // R7
        end
        CMD_LOCK_WRITE: begin
          // Only the three defined codes are taken
          if ((cmd_arg_i == ARG_W'(LOCK_NONE)) || (cmd_arg_i == ARG_W'(LOCK_ALL))
              || (cmd_arg_i == ARG_W'(LOCK_KNOB))) begin
            next_st.lock = cmd_arg_i[LOCK_W-1:0]; // R13 R16
          end
        end
        CMD_LOCK_READ: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_value = CODE_W'(st.lock); // R14
        end
        default: begin
          // Other commands only affect remote entry
        end
      endcase
    end
    // Derived outputs, registered so every pin is a flop
    // Ramp only applies under remote control
    next_st.ramp = next_st.remote && !next_st.opt[OPT_NO_RAMP]; // R8
    next_st.vf_sel = next_st.opt[OPT_SENSE_VF]; // R9
    next_st.cooler_en = cooler_en_req_i;
    // Linked: laser follows the cooler enable state
    if (!next_st.opt[OPT_UNLINK_EN]) begin
      next_st.laser_en = cooler_en_req_i; // R10
    end else begin
      next_st.laser_en = laser_en_req_i; // R10
    end
    next_st.buttons_en = (next_st.lock != LOCK_ALL); // R13
    next_st.knob_en = (next_st.lock == LOCK_NONE); // R13 R16
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.opt <= OPT_RESET; // R11
      st.lock <= LOCK_NONE; // R16
      st.ramp <= 1'b0;
      st.buttons_en <= 1'b1;
      st.knob_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_valid_o = st.rsp_valid;
  assign rsp_value_o = st.rsp_value;
  assign rsp_text_o = st.rsp_text;
  assign remote_o = st.remote;
  assign ramp_o = st.ramp;
  assign vf_sense_sel_o = st.vf_sel;
  assign laser_en_o = st.laser_en;
  assign cooler_en_o = st.cooler_en;
  assign buttons_en_o = st.buttons_en;
  assign knob_en_o = st.knob_en;
  assign options_o = st.opt;
  assign lockout_o = st.lock;

endmodule : sce_top

//--- sce_pkg.sv
// Constants for the system command block, plus its error code queue
//
// What this block does
// R1 - Error query returns one logged code, else zero
// R2 - Reading an error removes it from queue
// R3 - Error text query returns code plus text; zero has no text
// R4 - Options write stores value 0 to 255
// R5 - Bit 0 clear: any command but local enters remote
// R6 - Bit 0 set: only set commands enter remote
// R7 - Return-to-local command leaves remote mode
// R8 - Remote, bit 1 clear ramps; set applies immediately
// R9 - Bit 5 selects sense or terminal voltage
// R10 - Bit 7 clear links laser and cooler enables
// R11 - All option bits reset to zero
// R12 - Options query returns register contents
// R13 - Lockout codes: 0 none, 1 all, 2 knob
// R14 - Lockout query returns code in force
// R15 - Reserved option bits stored, no effect
// R16 - Enabled lockout value is code zero

// ****************************************************************
// Shared package
// ****************************************************************
package sce_pkg;

  // Widths of command arguments and reply words
  localparam int ARG_W = 16;
  localparam int CODE_W = 16;
  localparam int OPT_W = 8;
  localparam int LOCK_W = 2;
  localparam int ERRQ_DEPTH = 8;

  // Largest legal options value
  localparam logic [ARG_W-1:0] OPT_MAX = 16'h00ff;
  // Factory default of the options register
  localparam logic [OPT_W-1:0] OPT_RESET = 8'h00;

  // Option bit positions
  localparam int OPT_REMOTE_SET_ONLY = 0;
  localparam int OPT_NO_RAMP = 1;
  localparam int OPT_SENSE_VF = 5;
  localparam int OPT_UNLINK_EN = 7;

  // Lockout codes
  localparam logic [LOCK_W-1:0] LOCK_NONE = 2'h0;
  localparam logic [LOCK_W-1:0] LOCK_ALL = 2'h1;
  localparam logic [LOCK_W-1:0] LOCK_KNOB = 2'h2;

  // Empty-queue reply code
  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;

  // Decoded command codes from the text parser
  typedef enum logic [2:0] {
    CMD_OTHER = 3'h0,
    CMD_ERR_QUERY = 3'h1,
    CMD_ERR_TEXT_QUERY = 3'h2,
    CMD_OPT_WRITE = 3'h3,
    CMD_OPT_READ = 3'h4,
    CMD_LOCAL = 3'h5,
    CMD_LOCK_WRITE = 3'h6,
    CMD_LOCK_READ = 3'h7
  } sce_cmd_e;

endpackage : sce_pkg

// ****************************************************************
// Error code queue
// ****************************************************************
`timescale 1ns/1ps
module sce_errq
  import sce_pkg::*;
#(
  parameter int DEPTH = ERRQ_DEPTH,
  parameter int W = CODE_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [W-1:0] push_code_i,
  input wire logic pop_i,
  output logic [W-1:0] head_o,
  output logic empty_o
);

  localparam int PW = $clog2(DEPTH);

  // Whole queue state in one record
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] cnt;
  } sce_q_s;

  sce_q_s q;
  sce_q_s next_q;
  logic do_push;
  logic do_pop;

  // Next-state logic; a full queue drops the newest error
  always_comb begin
    next_q = q;
    do_pop = pop_i && (q.cnt != '0); // R2
    // Push still lands when a pop happens in the same cycle
    do_push = push_i && ((q.cnt != DEPTH[PW:0]) || do_pop);
    if (do_push) begin
      next_q.mem[q.wr] = push_code_i;
      next_q.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (do_pop) begin
      next_q.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1; // R2
    end
    next_q.cnt = q.cnt + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Head reads zero when nothing is pending
  assign empty_o = (q.cnt == '0);
  assign head_o = empty_o ? CODE_NONE : q.mem[q.rd]; // R1

endmodule : sce_errq

//--- sce_monitor.sv
// Port checker for the system command block
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module sce_mon
  import sce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic cmd_is_set_i,
  input wire logic [ARG_W-1:0] cmd_arg_i,
  input wire logic laser_en_req_i,
  input wire logic cooler_en_req_i,
  input wire logic rsp_valid_o,
  input wire logic [CODE_W-1:0] rsp_value_o,
  input wire logic rsp_text_o,
  input wire logic remote_o,
  input wire logic ramp_o,
  input wire logic vf_sense_sel_o,
  input wire logic laser_en_o,
  input wire logic buttons_en_o,
  input wire logic knob_en_o,
  input wire logic [OPT_W-1:0] options_o,
  input wire logic [LOCK_W-1:0] lockout_o
);
  // One domain, so one clock and one reset for all
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_REPLY: assert property (rsp_valid_o == $past(cmd_valid_i && cmd_code_i inside {1, 2, 4, 7}))
    else $error("reply strobe wrong");
  AST_TEXT: assert property (cmd_valid_i && cmd_code_i == CMD_ERR_TEXT_QUERY |=>
    rsp_text_o == (rsp_value_o != CODE_NONE)) else $error("text flag wrong");
  AST_OPT_RD: assert property (cmd_valid_i && cmd_code_i == CMD_OPT_READ |=>
    rsp_value_o == {8'h00, $past(options_o)}) else $error("options reply wrong");
  // Out-of-range writes must leave the register alone
  AST_OPT_WR: assert property (cmd_valid_i && cmd_code_i == CMD_OPT_WRITE |=> options_o ==
    ($past(cmd_arg_i) <= OPT_MAX ? $past(cmd_arg_i[7:0]) : $past(options_o)))
    else $error("options write wrong");
  AST_REMOTE_IN: assert property (cmd_valid_i && cmd_code_i != CMD_LOCAL &&
    (cmd_is_set_i || !options_o[0]) |=> remote_o) else $error("remote entry missed");
  AST_REMOTE_HOLD: assert property (!remote_o && !(cmd_valid_i &&
    (cmd_is_set_i || !options_o[0])) |=> !remote_o) else $error("remote entered by query");
  AST_LOCAL: assert property (cmd_valid_i && cmd_code_i == CMD_LOCAL |=> !remote_o)
    else $error("local not taken");
  AST_RAMP: assert property ($stable({remote_o, options_o[1]}) |->
    ramp_o == (remote_o && !options_o[1])) else $error("ramp wrong");
  AST_VF: assert property (vf_sense_sel_o == options_o[5])
    else $error("voltage select wrong");
  // Enable flop lags its request by one edge; the edge after reset still shows zero
  AST_LINK: assert property (!$past(rst_i) |-> laser_en_o ==
    (options_o[7] ? $past(laser_en_req_i) : $past(cooler_en_req_i))) else $error("link wrong");
  AST_PANEL: assert property ($stable(lockout_o) |-> buttons_en_o == (lockout_o != LOCK_ALL) &&
    knob_en_o == (lockout_o == LOCK_NONE)) else $error("panel enables wrong");
  // Main scenarios
  cover property (remote_o && options_o[0]);
  cover property (rsp_text_o);
  cover property (!buttons_en_o);
endmodule : sce_mon
bind sce_top sce_mon u_mon (.clk_i, .rst_i, .cmd_valid_i, .cmd_code_i, .cmd_is_set_i,
  .cmd_arg_i, .laser_en_req_i, .cooler_en_req_i, .rsp_valid_o, .rsp_value_o, .rsp_text_o,
  .remote_o, .ramp_o, .vf_sense_sel_o, .laser_en_o, .buttons_en_o, .knob_en_o, .options_o,
  .lockout_o);

//--- sce_host.sv
// Host model that issues decoded commands
`timescale 1ns/1ps
module sce_host
  import sce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rsp_valid_i,
  input wire logic [CODE_W-1:0] rsp_value_i,
  input wire logic rsp_text_i,
  output logic cmd_valid_o,
  output logic [2:0] cmd_code_o,
  output logic cmd_is_set_o,
  output logic [ARG_W-1:0] cmd_arg_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 3'h0;
    cmd_is_set_o = 1'b0;
    cmd_arg_o = 16'h0000;
  end
  // One command a call; the reply strobe stands one cycle, so sample it then
  task automatic send(input logic [2:0] c, input logic s, input logic [ARG_W-1:0] a,
                      output logic v, output logic [CODE_W-1:0] val, output logic t);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    cmd_is_set_o <= s;
    cmd_arg_o <= a;
    @(posedge clk_i);
    // Released argument shows junk, never the old value
    cmd_valid_o <= 1'b0;
    cmd_arg_o <= ~a;
    #1;
    v = rsp_valid_i;
    val = rsp_value_i;
    t = rsp_text_i;
  endtask : send
endmodule : sce_host

//--- tb.sv
// Self-checking testbench for the system command block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb
  import sce_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic elog = 1'b0;
  logic len = 1'b0;
  logic cen = 1'b0;
  logic [CODE_W-1:0] ecode = 16'h0000;
  logic cv, cs, rsv, rtx, rem, ramp, vf, len_o, cen_o, btn, knob, rv, rt;
  logic [2:0] cc;
  logic [ARG_W-1:0] ca;
  logic [CODE_W-1:0] rsval, rval;
  logic [OPT_W-1:0] opt;
  logic [LOCK_W-1:0] lock;
  int err_total = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  // Small queue so that overflow is reached quickly
  sce_top #(.DEPTH(2)) u_dut (.clk_i(clk), .rst_i(rst), .cmd_valid_i(cv), .cmd_code_i(cc),
    .cmd_is_set_i(cs), .cmd_arg_i(ca), .err_log_i(elog), .err_code_i(ecode),
    .laser_en_req_i(len), .cooler_en_req_i(cen), .rsp_valid_o(rsv), .rsp_value_o(rsval),
    .rsp_text_o(rtx), .remote_o(rem), .ramp_o(ramp), .vf_sense_sel_o(vf), .laser_en_o(len_o),
    .cooler_en_o(cen_o), .buttons_en_o(btn), .knob_en_o(knob), .options_o(opt),
    .lockout_o(lock));
  sce_host u_host (.clk_i(clk), .rsp_valid_i(rsv), .rsp_value_i(rsval), .rsp_text_i(rtx),
    .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_is_set_o(cs), .cmd_arg_o(ca));
  // Command, then two edges so derived outputs settle
  task automatic cmd(input logic [2:0] c, input logic s, input logic [ARG_W-1:0] a);
    u_host.send(c, s, a, rv, rval, rt);
    repeat (2) @(posedge clk);
    #1;
  endtask : cmd
  task automatic log_err(input logic [CODE_W-1:0] c);
    @(posedge clk);
    elog <= 1'b1;
    ecode <= c;
    @(posedge clk);
    elog <= 1'b0;
  endtask : log_err
  task automatic t_reset;
    `CHK({opt, lock}, 10'h000)
    `CHK({btn, knob, rem, vf, ramp}, 5'h18)
    $display("reset test done");
  endtask : t_reset
  task automatic t_errors;
    cmd(CMD_ERR_QUERY, 1'b0, 16'h0000);
    `CHK({rv, rval}, 17'h1_0000)
    log_err(16'h0005);
    log_err(16'h0006);
    log_err(16'h0007);
    cmd(CMD_ERR_QUERY, 1'b0, 16'h0000);
    `CHK({rval, rt}, 17'h0_000a)
    cmd(CMD_ERR_TEXT_QUERY, 1'b0, 16'h0000);
    `CHK({rval, rt}, 17'h0_000d)
    cmd(CMD_ERR_QUERY, 1'b0, 16'h0000);
    `CHK(rval, 16'h0000)
    cmd(CMD_ERR_TEXT_QUERY, 1'b0, 16'h0000);
    `CHK({rv, rval, rt}, 18'h2_0000)
    $display("error queue test done");
  endtask : t_errors
  task automatic t_remote;
    cmd(CMD_LOCAL, 1'b1, 16'h0000);
    `CHK(rem, 1'b0)
    cmd(CMD_OPT_READ, 1'b0, 16'h0000);
    `CHK({rem, rval}, 17'h1_0000)
    cmd(CMD_OPT_WRITE, 1'b1, 16'h012c);
    cmd(CMD_OPT_READ, 1'b0, 16'h0000);
    `CHK(rval, 16'h0000)
    cmd(CMD_OPT_WRITE, 1'b1, 16'h00ff);
    `CHK({opt, vf, ramp}, 10'h3fe)
    cmd(CMD_LOCAL, 1'b1, 16'h0000);
    cmd(CMD_ERR_QUERY, 1'b0, 16'h0000);
    `CHK(rem, 1'b0)
    // Any other set command still enters remote, with no reply
    cmd(CMD_OTHER, 1'b1, 16'h0000);
    `CHK({rem, rv}, 2'h2)
    $display("remote test done");
  endtask : t_remote
  task automatic t_lockout;
    cmd(CMD_LOCK_WRITE, 1'b1, 16'h0001);
    `CHK({rem, btn, knob, lock}, 5'h11)
    cmd(CMD_LOCK_READ, 1'b0, 16'h0000);
    `CHK(rval, 16'h0001)
    cmd(CMD_LOCK_WRITE, 1'b1, 16'h0002);
    `CHK({btn, knob, lock}, 4'ha)
    cmd(CMD_LOCK_WRITE, 1'b1, 16'h0003);
    `CHK(lock, LOCK_KNOB)
    cmd(CMD_LOCK_WRITE, 1'b1, 16'h0000);
    `CHK({btn, knob, lock}, 4'hc)
    $display("lockout test done");
  endtask : t_lockout
  task automatic t_options;
    @(posedge clk);
    len <= 1'b1;
    cmd(CMD_OPT_READ, 1'b0, 16'h0000);
    `CHK({len_o, cen_o}, 2'h2)
    cmd(CMD_OPT_WRITE, 1'b1, 16'h0000);
    `CHK({len_o, ramp, vf}, 3'h2)
    @(posedge clk);
    cen <= 1'b1;
    cmd(CMD_OPT_READ, 1'b0, 16'h0000);
    `CHK({len_o, cen_o}, 2'h3)
    $display("options test done");
  endtask : t_options
  // Reset in mid-run with non-default state and a pending error
  task automatic t_mid_reset;
    cmd(CMD_OPT_WRITE, 1'b1, 16'h00a5);
    cmd(CMD_LOCK_WRITE, 1'b1, 16'h0002);
    log_err(16'h0009);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({opt, lock, rem}, 11'h000)
    `CHK({btn, knob}, 2'h3)
    cmd(CMD_ERR_QUERY, 1'b0, 16'h0000);
    `CHK({rv, rval, rem}, 18'h2_0001)
    $display("mid-run reset test done");
  endtask : t_mid_reset
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset;
    t_errors;
    t_remote;
    t_lockout;
    t_options;
    t_mid_reset;
    stop_test;
  end
  // Tests need about 125 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    stop_test;
  end
endmodule : tb
